// *** core/vmar_map.vh ***
`ifndef VMAR_MAP_VH
`define VMAR_MAP_VH

// Register indices; byte address is four times the index
`define VMAR_IDX_MODE 8'h10
`define VMAR_IDX_OUTCTL 8'h11
`define VMAR_IDX_LINELEN 8'h12
`define VMAR_IDX_FIELDLEN 8'h13
`define VMAR_IDX_QCK 8'h14
`define VMAR_IDX_CLKDIV 8'h15
`define VMAR_IDX_CLKCFG 8'h16
`define VMAR_IDX_COPROC 8'h18
`define VMAR_IDX_XOFS 8'h58
`define VMAR_IDX_XOFS_HI 8'h59
`define VMAR_IDX_YOFS 8'h5A
`define VMAR_IDX_YOFS_HI 8'h5B
`define VMAR_IDX_STATUS 8'h20

// Mode register fields
`define VMAR_MODE_SEL_HI 2
`define VMAR_MODE_SEL_LO 0
`define VMAR_MODE_RATE_BIT 3
`define VMAR_MODE_CIF 3'h0
`define VMAR_MODE_ANALOG 3'h1
`define VMAR_MODE_CROP_Q 3'h2
`define VMAR_MODE_SUB_Q 3'h3
`define VMAR_MODE_RST 8'h00

// Other field positions
`define VMAR_OUT_BLACK_BIT 5
`define VMAR_OUT_SHUF_BIT 7
`define VMAR_CFG_PRESC_BIT 7
`define VMAR_COPROC_BIT 0

// Reset values and the free qck value
`define VMAR_OUTCTL_RST 8'h80
`define VMAR_QCK_RST 8'h00
`define VMAR_QCK_FREE 8'h04
`define VMAR_CLKCFG_RST 8'h00
`define VMAR_COPROC_RST 8'h00

// Mode presets
`define VMAR_LL_PAL 9'd453
`define VMAR_LL_NTSC 9'd363
`define VMAR_LL_CIF25 9'd499
`define VMAR_LL_CIF30 9'd415
`define VMAR_LL_Q25 9'd249
`define VMAR_LL_Q30 9'd207
`define VMAR_FL_PAL 9'd311
`define VMAR_FL_NTSC 9'd261
`define VMAR_FL_CIF 9'd319
`define VMAR_FL_Q 9'd159
`define VMAR_DIV_ANALOG 4'h2
`define VMAR_DIV_CIF 4'h4
`define VMAR_DIV_Q 4'h8

// Window sizes, fixed starts and cropped quarter start limits
`define VMAR_W_FULL 9'd356
`define VMAR_H_FULL 9'd292
`define VMAR_W_NTSC 9'd306
`define VMAR_H_NTSC 9'd244
`define VMAR_W_Q 9'd180
`define VMAR_H_Q 9'd148
`define VMAR_X_FULL 9'd5
`define VMAR_Y_FULL 9'd5
`define VMAR_X_NTSC 9'd29
`define VMAR_Y_NTSC 9'd29
`define VMAR_X_Q 9'd93
`define VMAR_Y_Q 9'd77
`define VMAR_X_MIN 9'd1
`define VMAR_X_MAX 9'd185
`define VMAR_Y_MIN 9'd5
`define VMAR_Y_MAX 9'd149

`endif

// *** core/vmar_core.v ***
// How it works
// - Mode write forces line length preset.
// - Mode write forces field length preset.
// - Divider upper nibble holds mode divisor.
// - Free qck on for analog modes.
// - Extra black lines follow output bit.
// - Non-preferred coprocessor always gets black lines.
// - Prescaler divides input clock by 1.5.
// - Divider 8 bits, software writes lower nibble.
// - Lower nibble zero divides by one.
// - NTSC and quarter window sizes.
// - PAL and CIF read 356 by 292.
// - Windows centred inside the array.
// - Window starts on green-1 pixel.
// - Default horizontal shuffle, switchable off.
// - Address counters run from start to start plus size minus one.
// - Start coordinates fixed except cropped quarter.
// - Cropped quarter starts clipped to limits.
// - Black and dark rows never visible.
// - Cropped quarter may use edge columns.
// - Power-up mode is CIF 30 fps.
// - Rate bit picks 30/25 or 60/50.
// - Presets applied at mode write.
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "vmar_map.vh"

module vmar_core (
  // Clock and reset
  input wire clk_i,
  input wire nrst_i,
  // AXI4-Lite write address
  input wire [9:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  // AXI4-Lite write response
  output wire [1:0] s_axi_bresp_o,
  output wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  // AXI4-Lite read
  input wire [9:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output wire [31:0] s_axi_rdata_o,
  output wire [1:0] s_axi_rresp_o,
  output wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // Readout
  output wire pix_tick_o,
  output wire pix_valid_o,
  output wire frame_start_o,
  output wire [8:0] col_addr_o,
  output wire [8:0] row_addr_o,
  output wire free_qck_en_o,
  output wire extra_black_en_o
);

  reg [7:0] mode_q;
  reg [7:0] outctl_q;
  reg [8:0] linelen_q;
  reg [8:0] fieldlen_q;
  reg [7:0] qck_q;
  reg [7:0] clkdiv_q;
  reg [7:0] clkcfg_q;
  reg [7:0] coproc_q;
  reg [8:0] xofs_q;
  reg [8:0] yofs_q;

  // Timing in use by the running frame
  reg [8:0] act_ll_q;
  reg [8:0] act_fl_q;
  reg [7:0] act_div_q;
  reg [2:0] act_mode_q;

  // AXI slave state
  reg aw_full_q;
  reg w_full_q;
  reg [7:0] aw_idx_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;

  wire do_wr = aw_full_q && w_full_q && !bvalid_q;
  wire wr_lane0 = wstrb_q[0];

  assign s_axi_awready_o = !aw_full_q;
  assign s_axi_wready_o = !w_full_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = !rvalid_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;

  function mapped;
    input [7:0] idx;
    begin
      case (idx)
        `VMAR_IDX_MODE, `VMAR_IDX_OUTCTL, `VMAR_IDX_LINELEN, `VMAR_IDX_FIELDLEN,
        `VMAR_IDX_QCK, `VMAR_IDX_CLKDIV, `VMAR_IDX_CLKCFG, `VMAR_IDX_COPROC,
        `VMAR_IDX_XOFS, `VMAR_IDX_XOFS_HI, `VMAR_IDX_YOFS, `VMAR_IDX_YOFS_HI,
        `VMAR_IDX_STATUS: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  function [8:0] clip;
    input [8:0] v;
    input [8:0] lo;
    input [8:0] hi;
    begin
      if (v < lo) begin
        clip = lo;
      end else if (v > hi) begin
        clip = hi;
      end else begin
        clip = v;
      end
    end
  endfunction

  // Preset decode for a mode byte being written
  reg [2:0] wr_sel;
  reg wr_rate;
  reg [8:0] pre_ll;
  reg [8:0] pre_fl;
  reg [3:0] pre_div;
  reg pre_analog;

  always @* begin
    wr_sel = wdata_q[`VMAR_MODE_SEL_HI:`VMAR_MODE_SEL_LO];
    wr_rate = wdata_q[`VMAR_MODE_RATE_BIT];
    pre_analog = 1'b0;
    case (wr_sel)
      `VMAR_MODE_ANALOG: begin
        pre_analog = 1'b1;
        pre_ll = wr_rate ? `VMAR_LL_PAL : `VMAR_LL_NTSC;
        pre_fl = wr_rate ? `VMAR_FL_PAL : `VMAR_FL_NTSC;
        pre_div = `VMAR_DIV_ANALOG;
      end
      `VMAR_MODE_CROP_Q, `VMAR_MODE_SUB_Q: begin
        pre_ll = wr_rate ? `VMAR_LL_Q25 : `VMAR_LL_Q30;
        pre_fl = `VMAR_FL_Q;
        pre_div = `VMAR_DIV_Q;
      end
      default: begin
        pre_ll = wr_rate ? `VMAR_LL_CIF25 : `VMAR_LL_CIF30;
        pre_fl = `VMAR_FL_CIF;
        pre_div = `VMAR_DIV_CIF;
      end
    endcase
  end

  // Frame boundary flag from the readout counters
  wire frame_end;

  // Write channel and register file
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_idx_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      mode_q <= `VMAR_MODE_RST;
      outctl_q <= `VMAR_OUTCTL_RST;
      linelen_q <= `VMAR_LL_CIF30;
      fieldlen_q <= `VMAR_FL_CIF;
      qck_q <= `VMAR_QCK_RST;
      clkdiv_q <= {`VMAR_DIV_CIF, 4'h0};
      clkcfg_q <= `VMAR_CLKCFG_RST;
      coproc_q <= `VMAR_COPROC_RST;
      xofs_q <= `VMAR_X_Q;
      yofs_q <= `VMAR_Y_Q;
    end else begin
      if (s_axi_awvalid_i && !aw_full_q) begin
        aw_full_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr_i[9:2];
      end
      if (s_axi_wvalid_i && !w_full_q) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
      if (bvalid_q && s_axi_bready_i) begin
        bvalid_q <= 1'b0;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= mapped(aw_idx_q) ? 2'h0 : 2'h2;
        if (wr_lane0) begin
          case (aw_idx_q)
            `VMAR_IDX_MODE: begin
              // Presets land immediately; software overrides go after this write
              mode_q <= wdata_q[7:0];
              linelen_q <= pre_ll;
              fieldlen_q <= pre_fl;
              clkdiv_q <= {pre_div, clkdiv_q[3:0]};
              qck_q <= pre_analog ? `VMAR_QCK_FREE : `VMAR_QCK_RST;
              outctl_q[`VMAR_OUT_BLACK_BIT] <= pre_analog;
              if (wr_sel == `VMAR_MODE_CROP_Q) begin
                xofs_q <= `VMAR_X_Q;
                yofs_q <= `VMAR_Y_Q;
              end
            end
            `VMAR_IDX_OUTCTL: outctl_q <= wdata_q[7:0];
            `VMAR_IDX_LINELEN: linelen_q <= wdata_q[8:0];
            `VMAR_IDX_FIELDLEN: fieldlen_q <= wdata_q[8:0];
            `VMAR_IDX_QCK: qck_q <= wdata_q[7:0];
            `VMAR_IDX_CLKDIV: clkdiv_q[3:0] <= wdata_q[3:0];
            `VMAR_IDX_CLKCFG: clkcfg_q <= wdata_q[7:0];
            `VMAR_IDX_COPROC: coproc_q <= wdata_q[7:0];
            `VMAR_IDX_XOFS: xofs_q <= clip(wdata_q[8:0], `VMAR_X_MIN, `VMAR_X_MAX);
            `VMAR_IDX_YOFS: yofs_q <= clip(wdata_q[8:0], `VMAR_Y_MIN, `VMAR_Y_MAX);
            default: begin
            end
          endcase
        end
      end
    end
  end

  // Read channel: answer one cycle after the address is taken
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= 2'h0;
    end else if (rvalid_q) begin
      if (s_axi_rready_i) begin
        rvalid_q <= 1'b0;
      end
    end else if (s_axi_arvalid_i) begin
      rvalid_q <= 1'b1;
      rresp_q <= mapped(s_axi_araddr_i[9:2]) ? 2'h0 : 2'h2;
      case (s_axi_araddr_i[9:2])
        `VMAR_IDX_MODE: rdata_q <= {24'h000000, mode_q};
        `VMAR_IDX_OUTCTL: rdata_q <= {24'h000000, outctl_q};
        `VMAR_IDX_LINELEN: rdata_q <= {23'h000000, linelen_q};
        `VMAR_IDX_FIELDLEN: rdata_q <= {23'h000000, fieldlen_q};
        `VMAR_IDX_QCK: rdata_q <= {24'h000000, qck_q};
        `VMAR_IDX_CLKDIV: rdata_q <= {24'h000000, clkdiv_q};
        `VMAR_IDX_CLKCFG: rdata_q <= {24'h000000, clkcfg_q};
        `VMAR_IDX_COPROC: rdata_q <= {24'h000000, coproc_q};
        `VMAR_IDX_XOFS: rdata_q <= {23'h000000, xofs_q};
        `VMAR_IDX_YOFS: rdata_q <= {23'h000000, yofs_q};
        `VMAR_IDX_STATUS: rdata_q <= {2'h0, act_fl_q, act_ll_q, act_div_q, 1'b0, act_mode_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end

  // Pixel clock: optional 1.5 prescale, then system divisor, then user divisor
  reg [1:0] pre_cnt_q;
  reg [4:0] div_cnt_q;
  wire presc_on = clkcfg_q[`VMAR_CFG_PRESC_BIT];
  // Two ticks per three clocks gives the 1.5 ratio without a second clock
  wire pre_tick = presc_on ? (pre_cnt_q != 2'd2) : 1'b1;
  wire [4:0] sys_div = {1'b0, act_div_q[7:4]};
  // Any nonzero user setting halves the pixel rate
  wire [4:0] tot_div = (act_div_q[3:0] == 4'h0) ? sys_div : {sys_div[3:0], 1'b0};
  wire pix_tick = pre_tick && (div_cnt_q == tot_div - 5'd1);

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      pre_cnt_q <= 2'd0;
      div_cnt_q <= 5'd0;
    end else begin
      pre_cnt_q <= (pre_cnt_q == 2'd2) ? 2'd0 : pre_cnt_q + 2'd1;
      if (pre_tick) begin
        div_cnt_q <= pix_tick ? 5'd0 : div_cnt_q + 5'd1;
      end
    end
  end

  // Window geometry of the running mode
  reg [8:0] win_w;
  reg [8:0] win_h;
  reg [8:0] x0;
  reg [8:0] y0;
  wire act_rate = mode_q[`VMAR_MODE_RATE_BIT];
  reg act_rate_q;

  always @* begin
    case (act_mode_q)
      `VMAR_MODE_ANALOG: begin
        win_w = act_rate_q ? `VMAR_W_FULL : `VMAR_W_NTSC;
        win_h = act_rate_q ? `VMAR_H_FULL : `VMAR_H_NTSC;
        x0 = act_rate_q ? `VMAR_X_FULL : `VMAR_X_NTSC;
        y0 = act_rate_q ? `VMAR_Y_FULL : `VMAR_Y_NTSC;
      end
      `VMAR_MODE_CROP_Q: begin
        win_w = `VMAR_W_Q;
        win_h = `VMAR_H_Q;
        x0 = xofs_q;
        y0 = yofs_q;
      end
      `VMAR_MODE_SUB_Q: begin
        win_w = `VMAR_W_Q;
        win_h = `VMAR_H_Q;
        x0 = `VMAR_X_Q;
        y0 = `VMAR_Y_Q;
      end
      default: begin
        win_w = `VMAR_W_FULL;
        win_h = `VMAR_H_FULL;
        x0 = `VMAR_X_FULL;
        y0 = `VMAR_Y_FULL;
      end
    endcase
  end

  // Readout counters
  reg [8:0] hcnt_q;
  reg [8:0] vcnt_q;
  reg [8:0] col_q;
  reg [8:0] row_q;
  reg valid_q;
  reg tick_q;
  reg fstart_q;
  wire line_end = pix_tick && (hcnt_q >= act_ll_q);
  assign frame_end = line_end && (vcnt_q >= act_fl_q);
  wire active = (hcnt_q < win_w) && (vcnt_q < win_h);
  wire [8:0] half_w = {1'b0, win_w[8:1]};
  // Even pixels of the row first, then the odd ones
  wire [8:0] shuf_idx = (hcnt_q < half_w) ? {hcnt_q[7:0], 1'b0} :
                        {hcnt_q[7:0] - half_w[7:0], 1'b1};
  wire [8:0] col_idx = outctl_q[`VMAR_OUT_SHUF_BIT] ? shuf_idx : hcnt_q;

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      hcnt_q <= 9'd0;
      vcnt_q <= 9'd0;
      col_q <= 9'h000;
      row_q <= 9'h000;
      valid_q <= 1'b0;
      tick_q <= 1'b0;
      fstart_q <= 1'b0;
      act_ll_q <= `VMAR_LL_CIF30;
      act_fl_q <= `VMAR_FL_CIF;
      act_div_q <= {`VMAR_DIV_CIF, 4'h0};
      act_mode_q <= `VMAR_MODE_CIF;
      act_rate_q <= 1'b0;
    end else begin
      tick_q <= pix_tick;
      fstart_q <= frame_end;
      if (frame_end) begin
        // Swap timing only between frames so no frame mixes two settings
        act_ll_q <= linelen_q;
        act_fl_q <= fieldlen_q;
        act_div_q <= clkdiv_q;
        act_mode_q <= mode_q[`VMAR_MODE_SEL_HI:`VMAR_MODE_SEL_LO];
        act_rate_q <= act_rate;
      end
      if (pix_tick) begin
        hcnt_q <= line_end ? 9'd0 : hcnt_q + 9'd1;
        if (line_end) begin
          vcnt_q <= frame_end ? 9'd0 : vcnt_q + 9'd1;
        end
        valid_q <= active;
        if (active) begin
          col_q <= x0 + col_idx;
          row_q <= y0 + vcnt_q;
        end
      end
    end
  end

  assign pix_tick_o = tick_q;
  assign pix_valid_o = valid_q && tick_q;
  assign frame_start_o = fstart_q;
  assign col_addr_o = col_q;
  assign row_addr_o = row_q;
  assign free_qck_en_o = (qck_q == `VMAR_QCK_FREE);
  assign extra_black_en_o = outctl_q[`VMAR_OUT_BLACK_BIT] ||
                            !coproc_q[`VMAR_COPROC_BIT];

endmodule

`default_nettype wire

// *** sim/vmar_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module vmar_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Bus handshakes
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Readout
  input wire logic pix_tick_o,
  input wire logic pix_valid_o,
  input wire logic [8:0] row_addr_o,
  input wire logic free_qck_en_o,
  input wire logic extra_black_en_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_wr_take;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  // Both halves are parked for one cycle before the register file is written
  property p_wr_answer; s_wr_take |-> ##2 s_axi_bvalid_o; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_rd_answer; s_rd_take |=> s_axi_rvalid_o; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_b_hold;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_ar_refuse; s_axi_rvalid_o |-> !s_axi_arready_o; endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("read taken while answering");
  property p_valid_tick; pix_valid_o |-> pix_tick_o; endproperty
  a_valid_tick: assert property (p_valid_tick) else $error("valid without tick");
  property p_row_visible;
    pix_valid_o |-> row_addr_o >= 9'h005 && row_addr_o <= 9'h128;
  endproperty
  a_row_visible: assert property (p_row_visible) else $error("hidden row read");
  property p_tick_pulse; pix_tick_o |=> !pix_tick_o; endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick too wide");
  property p_reset_defaults; $rose(nrst_i) |-> !free_qck_en_o && extra_black_en_o; endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("bad reset outputs");
endmodule
bind vmar_core vmar_checker u_chk (.*);
`default_nettype wire

// *** sim/vmar_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module vmar_host (
  // Clock
  input wire logic clk_i,
  // Requests
  output logic [9:0] s_axi_awaddr_i,
  output logic s_axi_awvalid_i,
  output logic [31:0] s_axi_wdata_i,
  output logic [3:0] s_axi_wstrb_i,
  output logic s_axi_wvalid_i,
  output logic s_axi_bready_i,
  output logic [9:0] s_axi_araddr_i,
  output logic s_axi_arvalid_i,
  output logic s_axi_rready_i,
  // Answers
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o
);
  // Cycles before taking an answer; 2 or more makes the slave hold a read answer, 3 or more a write answer
  int slow = 0;
  // Byte lanes offered with the next write; lane 0 clear writes nothing
  logic [3:0] strb = 4'hF;
  initial begin
    {s_axi_awaddr_i, s_axi_awvalid_i, s_axi_wdata_i, s_axi_wvalid_i} = '0;
    {s_axi_araddr_i, s_axi_arvalid_i, s_axi_bready_i, s_axi_rready_i} = '0;
    s_axi_wstrb_i = 4'hF;
  end
  // One write at a time keeps preset overrides after the mode write
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, output logic [1:0] resp);
    int k;
    logic aw_go, w_go, b_go;
    k = 0;
    @(posedge clk_i);
    s_axi_awaddr_i <= {idx, 2'b00};
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= strb;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= (slow == 0);
    do begin
      // Mid-cycle values are what the next rising edge samples; avoids the edge race
      @(negedge clk_i);
      aw_go = s_axi_awvalid_i && s_axi_awready_o;
      w_go = s_axi_wvalid_i && s_axi_wready_o;
      b_go = s_axi_bvalid_o && s_axi_bready_i;
      resp = s_axi_bresp_o;
      @(posedge clk_i);
      k++;
      if (aw_go) s_axi_awvalid_i <= 1'b0;
      if (w_go) s_axi_wvalid_i <= 1'b0;
      if (k >= slow && !b_go) s_axi_bready_i <= 1'b1;
    end while (!b_go);
    s_axi_bready_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
    int k;
    logic ar_go, r_go;
    k = 0;
    @(posedge clk_i);
    s_axi_araddr_i <= {idx, 2'b00};
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= (slow == 0);
    do begin
      @(negedge clk_i);
      ar_go = s_axi_arvalid_i && s_axi_arready_o;
      r_go = s_axi_rvalid_o && s_axi_rready_i;
      d = s_axi_rdata_o;
      resp = s_axi_rresp_o;
      @(posedge clk_i);
      k++;
      if (ar_go) s_axi_arvalid_i <= 1'b0;
      if (k >= slow && !r_go) s_axi_rready_i <= 1'b1;
    end while (!r_go);
    s_axi_rready_i <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** sim/tb_video_mode_arbitration_readout.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "vmar_map.vh"
module tb_video_mode_arbitration_readout;
  logic clk_i;
  logic nrst_i;
  wire [9:0] s_axi_awaddr_i, s_axi_araddr_i;
  wire [31:0] s_axi_wdata_i, s_axi_rdata_o;
  wire [3:0] s_axi_wstrb_i;
  wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
  wire s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
  wire s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
  wire pix_tick_o, pix_valid_o, frame_start_o, free_qck_en_o, extra_black_en_o;
  wire [8:0] col_addr_o, row_addr_o;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  vmar_core u_dut (.*);
  vmar_host u_host (.*);
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // A whole frame is far longer than this run, so a hang ends well before it
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic wchk(input logic [7:0] idx, input logic [31:0] d);
    logic [1:0] r;
    u_host.wr(idx, d, r);
    check("bresp", {30'h0, r}, 32'h0);
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    u_host.rd(idx, d, r);
    check("rdata", d, exp);
  endtask
  task automatic t_readout;
    int h, last, e;
    h = 0;
    last = 0;
    while (h <= 356) begin
      @(posedge clk_i);
      #1;
      if (pix_valid_o === 1'b1) begin
        if (h == 356) begin
          check("next_row", {23'h0, row_addr_o}, `VMAR_Y_FULL + 1);
          check("next_col", {23'h0, col_addr_o}, `VMAR_X_FULL);
        end else begin
          e = (h < `VMAR_W_FULL / 2) ? 2 * h : 2 * (h - `VMAR_W_FULL / 2) + 1;
          check("col", {23'h0, col_addr_o}, `VMAR_X_FULL + e);
          check("row", {23'h0, row_addr_o}, `VMAR_Y_FULL);
          check("fstart", frame_start_o, 1'b0);
          if (h > 0) check("gap", cycles - last, 4);
        end
        last = cycles;
        h++;
      end
    end
  endtask
  task automatic t_reset;
    rchk(`VMAR_IDX_MODE, `VMAR_MODE_RST);
    rchk(`VMAR_IDX_LINELEN, `VMAR_LL_CIF30);
    rchk(`VMAR_IDX_FIELDLEN, `VMAR_FL_CIF);
    rchk(`VMAR_IDX_CLKDIV, 8'h40);
    rchk(`VMAR_IDX_OUTCTL, `VMAR_OUTCTL_RST);
    check("black", extra_black_en_o, 1'b1);
    wchk(`VMAR_IDX_COPROC, 8'h01);
  endtask
  task automatic t_modes;
    logic [7:0] md [8] = '{8'h09, 8'h01, 8'h08, 8'h00, 8'h0A, 8'h02, 8'h0B, 8'h03};
    logic [8:0] ll [8] = '{`VMAR_LL_PAL, `VMAR_LL_NTSC, `VMAR_LL_CIF25, `VMAR_LL_CIF30,
      `VMAR_LL_Q25, `VMAR_LL_Q30, `VMAR_LL_Q25, `VMAR_LL_Q30};
    logic [8:0] fl [8] = '{`VMAR_FL_PAL, `VMAR_FL_NTSC, `VMAR_FL_CIF, `VMAR_FL_CIF,
      `VMAR_FL_Q, `VMAR_FL_Q, `VMAR_FL_Q, `VMAR_FL_Q};
    logic [3:0] dv [8] = '{4'h2, 4'h2, 4'h4, 4'h4, 4'h8, 4'h8, 4'h8, 4'h8};
    logic an;
    for (int i = 0; i < 8; i++) begin
      an = (i < 2);
      wchk(`VMAR_IDX_MODE, md[i]);
      rchk(`VMAR_IDX_LINELEN, ll[i]);
      rchk(`VMAR_IDX_FIELDLEN, fl[i]);
      rchk(`VMAR_IDX_CLKDIV, {dv[i], 4'h0});
      rchk(`VMAR_IDX_QCK, an ? `VMAR_QCK_FREE : `VMAR_QCK_RST);
      rchk(`VMAR_IDX_OUTCTL, an ? 8'hA0 : 8'h80);
      check("qck_en", free_qck_en_o, an);
      check("black", extra_black_en_o, an);
    end
  endtask
  task automatic t_override;
    u_host.slow = 3;
    wchk(`VMAR_IDX_MODE, 8'h00);
    wchk(`VMAR_IDX_QCK, `VMAR_QCK_FREE);
    check("qck_en", free_qck_en_o, 1'b1);
    wchk(`VMAR_IDX_OUTCTL, 8'hA0);
    rchk(`VMAR_IDX_OUTCTL, 8'hA0);
    check("black", extra_black_en_o, 1'b1);
    wchk(`VMAR_IDX_CLKDIV, 8'hFF);
    rchk(`VMAR_IDX_CLKDIV, 8'h4F);
    wchk(`VMAR_IDX_CLKCFG, 8'h80);
    rchk(`VMAR_IDX_CLKCFG, 8'h80);
    rchk(`VMAR_IDX_MODE, 8'h00);
    u_host.slow = 0;
  endtask
  task automatic t_crop;
    logic [7:0] ix [6] = '{`VMAR_IDX_XOFS, `VMAR_IDX_XOFS, `VMAR_IDX_XOFS,
      `VMAR_IDX_YOFS, `VMAR_IDX_YOFS, `VMAR_IDX_YOFS};
    logic [7:0] wv [6] = '{8'h00, 8'hC8, 8'h21, 8'h04, 8'hFA, 8'h95};
    logic [7:0] ev [6] = '{8'h01, 8'hB9, 8'h21, 8'h05, 8'h95, 8'h95};
    logic [31:0] d;
    logic [1:0] r;
    wchk(`VMAR_IDX_MODE, {5'h00, `VMAR_MODE_CROP_Q});
    rchk(`VMAR_IDX_XOFS, `VMAR_X_Q);
    rchk(`VMAR_IDX_YOFS, `VMAR_Y_Q);
    for (int i = 0; i < 6; i++) begin
      wchk(ix[i], wv[i]);
      rchk(ix[i], ev[i]);
    end
    u_host.strb = 4'h0;
    wchk(`VMAR_IDX_XOFS, 8'h41);
    u_host.strb = 4'hF;
    rchk(`VMAR_IDX_XOFS, 8'h21);
    rchk(`VMAR_IDX_XOFS_HI, 32'h0);
    u_host.rd(8'h30, d, r);
    check("rresp", {30'h0, r}, 32'h2);
    check("rdata", d, 32'h0);
  endtask
  initial begin
    nrst_i = 1'b0;
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_readout();
    t_reset();
    t_modes();
    t_override();
    t_crop();
    test_done();
  end
endmodule
`default_nettype wire
